/* File: src/vlfd_pkg.sv */
package vlfd_pkg;

   // ***************************************************************
   // format classes: 32-bit first, then 3-bit and 5-bit 16-bit ones
   // ***************************************************************
   typedef enum logic [4:0] {
      F_R0I0, F_R0I8, F_R0I16, F_R0I26, F_R1I0, F_R1I2, F_R1I7, F_R1I8,
      F_R1I10, F_R1I16, F_R2I0, F_R2I2, F_R2I3, F_R2I4, F_R2I5, F_R2I10,
      F_R2I16, F_R3I0, F_R3I3, F_R4I0, F_R2I12, F_R1I12,
      F_S3R0I0, F_S3R0I10, F_S3R1I7, F_S3R2I0, F_S3R2I3, F_S3R2I4,
      F_S3R3I1, F_S5R1I0, F_S5R1I4, F_S5R2I0
   } vlfd_fmt_t;

   // ***************************************************************
   // field positions and sizes
   // ***************************************************************
   localparam int         NUM_FMT32      = 22;
   localparam int         NUM_FMT16      = 10;
   localparam int         OPC_HI         = 15;
   localparam int         OPC_LO         = 10;
   localparam int         REG5_W         = 5;
   localparam int         REG3_W         = 3;
   localparam int         SLOT_A_LO      = 21;
   localparam int         SLOT_B_LO      = 16;
   localparam int         SLOT_C_LO      = 11;
   localparam int         SLOT_D_LO      = 6;
   localparam int         MINOR_LO       = 0;
   localparam int         MINOR_W        = 6;
   localparam int         MINOR12_LO     = 12;
   localparam int         MINOR12_W      = 4;
   localparam int         BODY16_W       = 10;
   localparam logic [4:0] IMM26_W        = 5'h1A;
   localparam logic [4:0] IMM16_W        = 5'h10;
   localparam logic       RST_BIT        = 1'h0;
   localparam logic [15:0] RST_HW        = 16'h0000;

   // which major opcodes are 16-bit; value is arbitrary
   localparam logic [63:0] LEN16_MASK    = 64'hFFFF_FFFF_0000_0000;

   typedef enum {ST_IDLE, ST_SECOND} vlfd_state_t;

   function automatic logic op_is16(input logic [5:0] op);
      return LEN16_MASK[op];
   endfunction : op_is16

   // opcode to format mapping; table contents arbitrary
   function automatic vlfd_fmt_t op_format(input logic [5:0] op);
      if (op_is16(op))
         return vlfd_fmt_t'(5'(NUM_FMT32 + (int'(op) % NUM_FMT16)));
      return vlfd_fmt_t'(5'(int'(op) % NUM_FMT32));
   endfunction : op_format

   function automatic logic [2:0] fmt_regs(input vlfd_fmt_t f);
      unique case (f)
         F_R0I0, F_R0I8, F_R0I16, F_R0I26, F_S3R0I0, F_S3R0I10 : return 3'h0;
         F_R1I0, F_R1I2, F_R1I7, F_R1I8, F_R1I10, F_R1I16, F_R1I12,
         F_S3R1I7, F_S5R1I0, F_S5R1I4                         : return 3'h1;
         F_R2I0, F_R2I2, F_R2I3, F_R2I4, F_R2I5, F_R2I10, F_R2I16,
         F_R2I12, F_S3R2I0, F_S3R2I3, F_S3R2I4, F_S5R2I0      : return 3'h2;
         F_R3I0, F_R3I3, F_S3R3I1                             : return 3'h3;
         F_R4I0                                               : return 3'h4;
      endcase
   endfunction : fmt_regs

   function automatic logic [4:0] fmt_immw(input vlfd_fmt_t f);
      unique case (f)
         F_R0I8, F_R1I8                     : return 5'h08;
         F_R0I16, F_R1I16, F_R2I16          : return IMM16_W;
         F_R0I26                            : return IMM26_W;
         F_R1I2, F_R2I2                     : return 5'h02;
         F_R1I7, F_S3R1I7                   : return 5'h07;
         F_R1I10, F_R2I10, F_S3R0I10        : return 5'h0A;
         F_R2I3, F_R3I3, F_S3R2I3           : return 5'h03;
         F_R2I4, F_S3R2I4, F_S5R1I4         : return 5'h04;
         F_R2I5                             : return 5'h05;
         F_R2I12, F_R1I12                   : return 5'h0C;
         F_S3R3I1                           : return 5'h01;
         default                            : return 5'h00;
      endcase
   endfunction : fmt_immw

endpackage : vlfd_pkg

/* File: src/vlfd_fields_if.sv */
`timescale 1ns/10ps
interface vlfd_fields_if;
   import vlfd_pkg::*;
   logic [31:0] instr;
   logic        is32;
   vlfd_fmt_t   fmt;
   logic [2:0]  reg_count;
   logic [2:0]  reg_w;
   logic [4:0]  reg_a;
   logic [4:0]  reg_b;
   logic [4:0]  reg_c;
   logic [4:0]  reg_d;
   logic [25:0] imm;
   logic [4:0]  imm_w;
   logic [9:0]  minor;
   logic [3:0]  minor_w;
   logic [19:0] other;
   logic [4:0]  other_w;

   modport ext (input instr, is32, fmt, output reg_count, reg_w, reg_a, reg_b, reg_c, reg_d,
                imm, imm_w, minor, minor_w, other, other_w);
   modport top (output instr, is32, fmt, input reg_count, reg_w, reg_a, reg_b, reg_c, reg_d,
                imm, imm_w, minor, minor_w, other, other_w);
endinterface : vlfd_fields_if

/* File: src/vlfd_extract.sv */
`timescale 1ns/10ps
module vlfd_extract
(
   vlfd_fields_if.ext f
);
   import vlfd_pkg::*;

   function automatic logic [31:0] lowmask(input int w);
      return (32'h1 << w) - 32'h1;
   endfunction : lowmask

   // ***************************************************************
   // field extraction by format
   // ***************************************************************
   always_comb
   begin
      int        n;
      int        y;
      int        lo;
      int        rw;
      int        mw;
      logic [31:0] w;
      n = int'(fmt_regs(f.fmt));
      y = int'(fmt_immw(f.fmt));
      w = f.instr;
      lo = SLOT_D_LO;
      rw = 0;
      mw = 0;
      f.reg_count = fmt_regs(f.fmt);
      f.imm_w     = fmt_immw(f.fmt);
      f.reg_a     = 5'h00;
      f.reg_b     = 5'h00;
      f.reg_c     = 5'h00;
      f.reg_d     = 5'h00;
      f.imm       = 26'h0;
      f.minor     = 10'h0;
      f.minor_w   = 4'h0;
      f.other     = 20'h0;
      f.other_w   = 5'h00;
      if (f.is32)
      begin
         f.reg_w = 3'(REG5_W);
         // every 5-bit slot sits at one fixed place
         if (n >= 1) f.reg_a = w[SLOT_B_LO +: REG5_W];
         if (n >= 2) f.reg_b = w[SLOT_A_LO +: REG5_W];
         if (n >= 3) f.reg_c = w[SLOT_C_LO +: REG5_W];
         if (n >= 4) f.reg_d = w[SLOT_D_LO +: REG5_W];
         unique case (f.fmt)
            F_R0I26, F_R2I16 :
               f.imm = 26'(w & lowmask(y));
            F_R0I16 :
            begin
               f.imm     = 26'(w & lowmask(y));
               f.minor   = w[25:16];
               f.minor_w = 4'hA;
            end
            F_R1I16 :
            begin
               f.imm     = 26'(w & lowmask(y));
               f.minor   = 10'(w[25:21]);
               f.minor_w = 4'h5;
            end
            F_R1I12, F_R2I12 :
            begin
               f.imm     = 26'(w & lowmask(y));
               f.minor   = 10'(w[MINOR12_LO +: MINOR12_W]);
               f.minor_w = 4'(MINOR12_W);
               if (n == 1)
               begin
                  f.other   = 20'(w[25:21]);
                  f.other_w = 5'h05;
               end
            end
            default :
            begin
               // minor low, then empty and aux bits, imm on top of the free span
               f.minor   = 10'(w[MINOR_LO +: MINOR_W]);
               f.minor_w = 4'(MINOR_W);
               rw = (n == 0) ? 20 : (n <= 2) ? 10 : (n == 3) ? 5 : 0;
               f.imm     = 26'((w >> (lo + rw - y)) & lowmask(y));
               f.other   = 20'((w >> lo) & lowmask(rw - y));
               f.other_w = 5'(rw - y);
            end
         endcase
      end
      else if (f.fmt inside {F_S5R1I0, F_S5R1I4, F_S5R2I0})
      begin
         // halfword body sits in w[25:16]
         f.reg_w = 3'(REG5_W);
         if (n >= 1) f.reg_a = w[25:21];
         if (n >= 2) f.reg_b = w[20:16];
         mw = BODY16_W - REG5_W * n - y;
         f.minor   = 10'(32'(w[25:16]) & lowmask(mw));
         f.minor_w = 4'(mw);
         f.imm     = 26'((32'(w[25:16]) >> mw) & lowmask(y));
      end
      else
      begin
         // raw 3-bit codes; translation happens downstream
         f.reg_w = 3'(REG3_W);
         if (n >= 1) f.reg_a = 5'(w[25:23]);
         if (n >= 2) f.reg_b = 5'(w[22:20]);
         if (n >= 3) f.reg_c = 5'(w[19:17]);
         mw = BODY16_W - REG3_W * n - y;
         f.imm     = 26'(32'(w[25:16]) & lowmask(y));
         f.minor   = 10'((32'(w[25:16]) >> y) & lowmask(mw));
         f.minor_w = 4'(mw);
      end
   end
endmodule : vlfd_extract

/* File: src/vlfd_decoder.sv */
// What this block does
// - accept mixed 16-bit and 32-bit instructions
// - major opcode is top six bits
// - length comes from major opcode only
// - opcode picks minor position, immediate justification
// - 5-bit regs long, 3-bit or 5-bit regs short
// - zero to four register fields
// - 5-bit register slots at fixed positions
// - 26-bit immediate fills below opcode
// - right-justify 16/26-bit and some short immediates
// - offsets and jump targets count as immediates
// - aux fields between immediate and minor, except R1I12 (aux at bits 25..21)
// - aux fields alphabetical, first at lowest bit
// - unused bits sit next to minor opcode
// - classes named by register count, immediate width
// - short classes split by register width
// - opcode halfword is the first fetched
// - 5-bit specifier is plain register index
`timescale 1ns/10ps
module vlfd_decoder
   import vlfd_pkg::*;
(
   // clock and reset
   input  wire logic               CLK,
   input  wire logic               RESETN,
   // halfwords from fetch
   input  wire logic [15:0]        HW_DATA,
   input  wire logic               HW_VALID,
   input  wire logic               FLUSH,
   // decoded instruction
   output logic                    DEC_VALID,
   output logic                    DEC_IS32,
   output vlfd_pkg::vlfd_fmt_t     DEC_FORMAT,
   output logic [5:0]              DEC_MAJOR,
   output logic [2:0]              DEC_REG_COUNT,
   output logic [2:0]              DEC_REG_WIDTH,
   output logic [4:0]              SOURCE_REG_A,
   output logic [4:0]              SECOND_REG_FIELD,
   output logic [4:0]              DEST_REG_FIELD,
   output logic [4:0]              FOURTH_REG_FIELD,
   output logic [25:0]             DEC_IMM,
   output logic [4:0]              DEC_IMM_WIDTH,
   output logic [9:0]              DEC_MINOR,
   output logic [3:0]              DEC_MINOR_WIDTH,
   output logic [19:0]             DEC_OTHER,
   output logic [4:0]              DEC_OTHER_WIDTH,
   // status
   output logic                    PEND_SECOND
);
   import vlfd_pkg::*;

   // ***************************************************************
   // sequencing state
   // ***************************************************************
   vlfd_state_t  state;
   vlfd_state_t  next_state;
   logic [15:0]  first_hw;
   logic [15:0]  next_first_hw;
   logic [31:0]  dec_word;
   logic [31:0]  next_dec_word;
   logic         take;
   logic [5:0]   major;

   vlfd_fields_if fi ();

   vlfd_extract u_extract
   (
      .f (fi.ext)
   );

   // opcode halfword arrives first; second completes the word
   assign major    = (state == ST_SECOND) ? first_hw[OPC_HI:OPC_LO] : HW_DATA[OPC_HI:OPC_LO];
   assign fi.is32  = !op_is16(major);
   assign fi.fmt   = op_format(major);
   assign fi.instr = (state == ST_SECOND) ? {first_hw, HW_DATA} : {HW_DATA, RST_HW};
   assign take     = HW_VALID && !FLUSH && ((state == ST_SECOND) || !fi.is32);

   always_comb
   begin
      next_state    = state;
      next_first_hw = first_hw;
      next_dec_word = dec_word;
      if (FLUSH)
         next_state = ST_IDLE;
      else if (HW_VALID)
      begin
         unique case (state)
            ST_IDLE :
               if (fi.is32)
               begin
                  next_first_hw = HW_DATA;
                  next_state    = ST_SECOND;
               end
            ST_SECOND :
               next_state = ST_IDLE;
         endcase
      end
      if (take)
         next_dec_word = fi.instr;
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         state    <= ST_IDLE;
         first_hw <= RST_HW;
         dec_word <= 32'h0000_0000;
      end
      else
      begin
         state    <= next_state;
         first_hw <= next_first_hw;
         dec_word <= next_dec_word;
      end
   end

   // ***************************************************************
   // output registers
   // ***************************************************************
   logic               next_valid;
   logic               next_is32;
   vlfd_fmt_t          next_fmt;
   logic [5:0]         next_major;

   always_comb
   begin
      next_valid = take;
      next_is32  = take ? fi.is32 : DEC_IS32;
      next_fmt   = take ? fi.fmt : DEC_FORMAT;
      next_major = take ? major : DEC_MAJOR;
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         DEC_VALID        <= RST_BIT;
         DEC_IS32         <= RST_BIT;
         DEC_FORMAT       <= F_R0I0;
         DEC_MAJOR        <= 6'h00;
         DEC_REG_COUNT    <= 3'h0;
         DEC_REG_WIDTH    <= 3'h0;
         SOURCE_REG_A     <= 5'h00;
         SECOND_REG_FIELD <= 5'h00;
         DEST_REG_FIELD   <= 5'h00;
         FOURTH_REG_FIELD <= 5'h00;
         DEC_IMM          <= 26'h0;
         DEC_IMM_WIDTH    <= 5'h00;
         DEC_MINOR        <= 10'h0;
         DEC_MINOR_WIDTH  <= 4'h0;
         DEC_OTHER        <= 20'h0;
         DEC_OTHER_WIDTH  <= 5'h00;
         PEND_SECOND      <= RST_BIT;
      end
      else
      begin
         DEC_VALID   <= next_valid;
         DEC_IS32    <= next_is32;
         DEC_FORMAT  <= next_fmt;
         DEC_MAJOR   <= next_major;
         PEND_SECOND <= (next_state == ST_SECOND);
         if (take)
         begin
            DEC_REG_COUNT    <= fi.reg_count;
            DEC_REG_WIDTH    <= fi.reg_w;
            SOURCE_REG_A     <= fi.reg_a;
            SECOND_REG_FIELD <= fi.reg_b;
            DEST_REG_FIELD   <= fi.reg_c;
            FOURTH_REG_FIELD <= fi.reg_d;
            DEC_IMM          <= fi.imm;
            DEC_IMM_WIDTH    <= fi.imm_w;
            DEC_MINOR        <= fi.minor;
            DEC_MINOR_WIDTH  <= fi.minor_w;
            DEC_OTHER        <= fi.other;
            DEC_OTHER_WIDTH  <= fi.other_w;
         end
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_long_first;
      state == ST_IDLE && HW_VALID && !FLUSH && !op_is16(HW_DATA[OPC_HI:OPC_LO]);
   endsequence

   sequence s_long_second;
      HW_VALID && !FLUSH;
   endsequence

   sequence s_short;
      state == ST_IDLE && HW_VALID && !FLUSH && op_is16(HW_DATA[OPC_HI:OPC_LO]);
   endsequence

   AST_LEN_FROM_OPCODE: assert property (DEC_VALID |-> DEC_IS32 == !op_is16(DEC_MAJOR))
      else $error("length does not follow major opcode");

   AST_SHORT_ONE_HW: assert property (s_short |=> DEC_VALID && !DEC_IS32 && !PEND_SECOND)
      else $error("short instruction not decoded next cycle");

   AST_SHORT_MAJOR: assert property (s_short |=> DEC_MAJOR == $past(HW_DATA[OPC_HI:OPC_LO]))
      else $error("short major opcode not from bits 15..10");

   AST_LONG_TWO_HW: assert property (s_long_first ##1 s_long_second |=>
         DEC_VALID && DEC_IS32 && DEC_MAJOR == $past(HW_DATA[OPC_HI:OPC_LO], 2)
         && dec_word[15:0] == $past(HW_DATA))
      else $error("long instruction halfword order wrong");

   AST_LONG_WAITS: assert property (s_long_first |=> !DEC_VALID && PEND_SECOND)
      else $error("long instruction decoded from one halfword");

   AST_REG_FIXED: assert property (DEC_VALID && DEC_IS32 && DEC_REG_COUNT >= 3'h1 |->
         SOURCE_REG_A == dec_word[SLOT_B_LO +: REG5_W] && DEC_REG_WIDTH == 3'h5)
      else $error("5-bit register slot not at fixed position");

   AST_REG_FOUR: assert property (DEC_VALID && DEC_FORMAT == F_R4I0 |->
         DEC_REG_COUNT == 3'h4 && FOURTH_REG_FIELD == dec_word[SLOT_D_LO +: REG5_W])
      else $error("four register format not decoded");

   AST_IMM26: assert property (DEC_VALID && DEC_FORMAT == F_R0I26 |->
         DEC_IMM == dec_word[25:0] && DEC_IMM_WIDTH == IMM26_W)
      else $error("26-bit immediate wrong");

   AST_IMM16_RIGHT: assert property (DEC_VALID && DEC_IS32 && DEC_IMM_WIDTH == IMM16_W |->
         DEC_IMM == {10'h0, dec_word[15:0]})
      else $error("16-bit immediate not right-justified");

   AST_MINOR_I12: assert property (DEC_VALID && DEC_FORMAT == F_R2I12 |->
         DEC_MINOR == {6'h0, dec_word[MINOR12_LO +: MINOR12_W]})
      else $error("minor opcode position wrong");

   AST_S5_REGS: assert property (DEC_VALID && DEC_FORMAT == F_S5R2I0 |->
         SOURCE_REG_A == dec_word[25:21] && SECOND_REG_FIELD == dec_word[20:16])
      else $error("short 5-bit register fields misplaced");

   AST_FLUSH_DROPS: assert property (FLUSH |=> !DEC_VALID && !PEND_SECOND)
      else $error("flush did not clear pending state");

endmodule : vlfd_decoder

/* File: bench/vlfd_fetch_model.sv */
`timescale 1ns/10ps
module vlfd_fetch_model
(
   // clock
   input  wire logic        clk,
   // halfword stream
   output logic [15:0]      hw_data,
   output logic             hw_valid,
   output logic             flush
);

   initial
   begin
      hw_data  = 16'h0000;
      hw_valid = 1'h0;
      flush    = 1'h0;
   end

   // released bus toggles so no stale halfword survives
   task automatic idle();
      @(posedge clk);
      #1;
      hw_valid = 1'h0;
      flush    = 1'h0;
      hw_data  = ~hw_data;
   endtask : idle

   // one halfword after a stall of gap cycles, held for one edge
   task automatic put(input logic [15:0] d, input int gap, input logic fl);
      repeat (gap) idle();
      @(posedge clk);
      #1;
      hw_valid = 1'h1;
      flush    = fl;
      hw_data  = d;
   endtask : put

endmodule : vlfd_fetch_model

/* File: bench/vlfd_decoder_test.sv */
`timescale 1ns/10ps
module vlfd_decoder_test;
   import vlfd_pkg::*;

   typedef struct {
      logic        is32;
      logic [4:0]  fmt;
      logic [5:0]  op;
      logic [2:0]  rc;
      logic [2:0]  rw;
      logic [4:0]  ra, rb, rd, rf;
      logic [25:0] imm;
      logic [4:0]  iw;
      logic [9:0]  mn;
      logic [3:0]  mw;
      logic [19:0] ot;
      logic [4:0]  ow;
      logic        chk_mn, chk_ot;
   } vlfd_exp_t;

   logic        clk = 1'h0;
   logic        resetn = 1'h0;
   logic [15:0] hw_data;
   logic        hw_valid, flush, dec_valid, dec_is32, pend_second;
   vlfd_fmt_t   dec_format;
   logic [5:0]  dec_major;
   logic [2:0]  dec_reg_count, dec_reg_width;
   logic [4:0]  reg_a, reg_b, reg_c, reg_d, dec_imm_width, dec_other_width;
   logic [25:0] dec_imm;
   logic [9:0]  dec_minor;
   logic [3:0]  dec_minor_width;
   logic [19:0] dec_other;
   int          bad_count = 0;
   int          checked = 0;
   logic [15:0] rnd = 16'h004A;
   vlfd_exp_t   exp_q[$];

   initial
   begin
      forever #10 clk = ~clk;
   end

   vlfd_fetch_model fetch_u (.clk(clk), .hw_data(hw_data), .hw_valid(hw_valid), .flush(flush));

   vlfd_decoder dut_u (
      .CLK(clk), .RESETN(resetn), .HW_DATA(hw_data), .HW_VALID(hw_valid), .FLUSH(flush),
      .DEC_VALID(dec_valid), .DEC_IS32(dec_is32), .DEC_FORMAT(dec_format), .DEC_MAJOR(dec_major),
      .DEC_REG_COUNT(dec_reg_count), .DEC_REG_WIDTH(dec_reg_width), .SOURCE_REG_A(reg_a),
      .SECOND_REG_FIELD(reg_b), .DEST_REG_FIELD(reg_c), .FOURTH_REG_FIELD(reg_d),
      .DEC_IMM(dec_imm), .DEC_IMM_WIDTH(dec_imm_width), .DEC_MINOR(dec_minor),
      .DEC_MINOR_WIDTH(dec_minor_width), .DEC_OTHER(dec_other), .DEC_OTHER_WIDTH(dec_other_width),
      .PEND_SECOND(pend_second));

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("bad_count %0d checked %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   // expectation from the class name: R<x>I<y>, S3/S5 prefix
   function automatic vlfd_exp_t build_exp(input logic [31:0] w);
      vlfd_exp_t e;
      vlfd_fmt_t f;
      string     s;
      int        i;
      int        r;
      int        iw;
      int        top;
      logic [31:0] b;
      e = '{default: '0};
      e.chk_mn = 1'h1;
      e.chk_ot = 1'h1;
      e.op = w[31:26];
      e.is32 = ~LEN16_MASK[e.op];
      f = e.is32 ? vlfd_fmt_t'(5'(int'(e.op) % NUM_FMT32)) : vlfd_fmt_t'(5'(NUM_FMT32 + int'(e.op) % NUM_FMT16));
      e.fmt = f;
      s = f.name();
      i = 2;
      while (i < s.len() && s.getc(i) != "R")
         i++;
      r = s.getc(i + 1) - "0";
      iw = s.substr(i + 3, s.len() - 1).atoi();
      e.rc = 3'(r);
      e.iw = 5'(iw);
      e.rw = (s.getc(2) == "S" && s.getc(3) == "3") ? 3'h3 : 3'h5;
      if (e.is32)
      begin
         e.ra = (r >= 1) ? w[20:16] : 5'h00;
         e.rb = (r >= 2) ? w[25:21] : 5'h00;
         e.rd = (r >= 3) ? w[15:11] : 5'h00;
         e.rf = (r >= 4) ? w[10:6] : 5'h00;
         top = (r == 0) ? 25 : ((r <= 2) ? 15 : ((r == 3) ? 10 : 5));
         if (iw == 26)
            e.imm = w[25:0];
         else if (iw == 16 && r == 2)
            e.imm = 26'(w[15:0]);
         else if (iw == 16)
         begin
            e.imm = 26'(w[15:0]);
            e.mn = (r == 0) ? w[25:16] : 10'(w[25:21]);
            e.mw = (r == 0) ? 4'hA : 4'h5;
         end
         else if (iw == 12)
         begin
            e.imm = 26'(w[11:0]);
            e.mn = 10'(w[15:12]);
            e.mw = 4'h4;
            e.ot = (r == 1) ? 20'(w[25:21]) : 20'h0;
            e.ow = (r == 1) ? 5'h05 : 5'h00;
         end
         else
         begin
            e.imm = 26'((w >> (top + 1 - iw)) & ((32'h1 << iw) - 1));
            e.mn = 10'(w[5:0]);
            e.mw = 4'h6;
            e.ow = 5'(top - 5 - iw);
            e.ot = 20'((w >> 6) & ((32'h1 << (top - 5 - iw)) - 1));
         end
      end
      else
      begin
         // short body is halfword bits 9..0
         b = 32'(w[25:16]);
         if (e.rw == 3'h5)
         begin
            e.ra = (r >= 1) ? w[25:21] : 5'h00;
            e.rb = (r >= 2) ? w[20:16] : 5'h00;
            e.mw = 4'(10 - 5 * r - iw);
            e.mn = 10'(b & ((32'h1 << e.mw) - 1));
            e.imm = 26'((b >> e.mw) & ((32'h1 << iw) - 1));
         end
         else
         begin
            e.ra = (r >= 1) ? 5'(w[25:23]) : 5'h00;
            e.rb = (r >= 2) ? 5'(w[22:20]) : 5'h00;
            e.rd = (r >= 3) ? 5'(w[19:17]) : 5'h00;
            e.mw = 4'(10 - 3 * r - iw);
            e.imm = 26'(b & ((32'h1 << iw) - 1));
            e.mn = 10'((b >> iw) & ((32'h1 << e.mw) - 1));
         end
      end
      return e;
   endfunction : build_exp

   task automatic send_instr(input logic [31:0] w, input int gap);
      vlfd_exp_t e;
      e = build_exp(w);
      exp_q.push_back(e);
      fetch_u.put(w[31:16], gap, 1'h0);
      if (e.is32)
         fetch_u.put(w[15:0], gap, 1'h0);
   endtask : send_instr

   task automatic drain();
      int n;
      n = 0;
      fetch_u.idle();
      while (exp_q.size() != 0 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (exp_q.size() != 0)
      begin
         bad_count++;
         $display("FAIL drain expected 0 seen %0d", exp_q.size());
         finish_test();
      end
   endtask : drain

   // ***************************************************************
   // result watcher
   // ***************************************************************
   always @(negedge clk)
   begin
      vlfd_exp_t e;
      if (resetn === 1'h1 && dec_valid === 1'h1)
      begin
         if (exp_q.size() == 0)
            check("unexpected decode", 32'h1, 32'h0);
         else
         begin
            e = exp_q.pop_front();
            check("is32", 32'(dec_is32), 32'(e.is32));
            check("format", 32'(dec_format), 32'(e.fmt));
            check("major", 32'(dec_major), 32'(e.op));
            check("reg_count", 32'(dec_reg_count), 32'(e.rc));
            check("reg_width", 32'(dec_reg_width), 32'(e.rw));
            check("imm_width", 32'(dec_imm_width), 32'(e.iw));
            check("reg_a", 32'(reg_a), 32'(e.ra));
            check("reg_b", 32'(reg_b), 32'(e.rb));
            check("reg_c", 32'(reg_c), 32'(e.rd));
            check("reg_d", 32'(reg_d), 32'(e.rf));
            check("imm", 32'(dec_imm), 32'(e.imm));
            if (e.chk_mn)
            begin
               check("minor", 32'(dec_minor), 32'(e.mn));
               check("minor_width", 32'(dec_minor_width), 32'(e.mw));
            end
            if (e.chk_ot)
            begin
               check("other", 32'(dec_other), 32'(e.ot));
               check("other_width", 32'(dec_other_width), 32'(e.ow));
            end
         end
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      logic [15:0] r1;
      repeat (15) @(posedge clk);
      @(negedge clk);
      check("reset valid", 32'(dec_valid), 32'h0);
      check("reset pending", 32'(pend_second), 32'h0);
      check("reset format", 32'(dec_format), 32'(F_R0I0));
      @(posedge clk);
      #1;
      resetn = 1'h1;
      // every major opcode, back to back then with stalls
      for (int p = 0; p < 2; p++)
      begin
         for (int op = 0; op < 64; op++)
         begin
            r1 = lfsr(rnd);
            rnd = lfsr(r1);
            send_instr({6'(op), r1[9:0], rnd}, p ? int'(rnd[1:0]) : 0);
         end
      end
      drain();
      // lone first halfword, then flush with a short one alongside
      fetch_u.put(16'h0421, 0, 1'h0);
      fetch_u.idle();
      @(negedge clk);
      check("pending", 32'(pend_second), 32'h1);
      fetch_u.put(16'hFC00, 0, 1'h1);
      fetch_u.idle();
      @(negedge clk);
      check("flushed", 32'(pend_second), 32'h0);
      send_instr(32'h8D5A_0000, 0);
      drain();
      // reset while a first halfword waits
      fetch_u.put(16'h1084, 0, 1'h0);
      fetch_u.idle();
      resetn = 1'h0;
      fetch_u.idle();
      resetn = 1'h1;
      @(negedge clk);
      check("reset pending", 32'(pend_second), 32'h0);
      send_instr(32'hC3FF_0000, 0);
      send_instr(32'h0000_0000, 0);
      drain();
      repeat (4) @(posedge clk);
      finish_test();
   end

endmodule : vlfd_decoder_test
